// ### dpsc_map.svh
// constants for the dds profile sweep core
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH
`define DPSC_PHASE_W      48
`define DPSC_AMP_W        14
`define DPSC_POFF_W       14
`define DPSC_NUM_PROF     8
`define DPSC_SEL_W        3
`define DPSC_RATE_W       16
`define DPSC_SYNC_DIV     4
`define DPSC_CF1_NODWELL  16
`define DPSC_CF1_SWEEP_EN 17
`define DPSC_CF1_W        32
`define DPSC_FIFO_DEPTH   16
`define DPSC_LUT_ADDR_W   6
`define DPSC_CF1_RESET    32'h0000_0000
`endif

// ### dpsc_pkg.sv
// types for the dds profile sweep core
`default_nettype none
package dpsc_pkg;
  typedef enum logic [1:0]
  {
    DPSC_TONE  = 2'b00,
    DPSC_SWEEP = 2'b01
  } dpsc_mode_t;
  typedef logic [47:0] dpsc_word_t;
  typedef logic [13:0] dpsc_poff_t;
endpackage
`default_nettype wire

// ### dpsc_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`include "dpsc_map.svh"
`default_nettype none
module dpsc_fifo
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
)
(
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;
  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_in_data;
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ### dpsc_core.sv
// dds core: profiles, linear sweep, phase accumulator, cosine stage, dac fifo
//
// Summary of operation
// - 48-bit phase accumulator adds active tuning word each sample, wrapping
// - active profile phase offset added to accumulator phase before amplitude stage
// - amplitude stage outputs cosine of offset phase, full range is 2 pi
// - one 14-bit amplitude word toward the dac each sample clock
// - single-tone uses active profile tuning word and its static offset
// - eight profiles, each with 48-bit tuning word and 14-bit offset
// - active profile index equals binary value on three select pins
// - tuning word and offset come from one profile in single-tone; in sweep only the offset does
// - sweep active when control bit 17 set and bit 16 clear
// - sweep lower limit is profile 0 word, upper limit profile 1 word
// - select pin 0 high sweeps up, low sweeps down
// - sweeping up adds rising step word every rising interval sync cycles
// - sweeping down subtracts falling step word every falling interval sync cycles
// - upward step past upper limit clamps there, holds while pin high
// - downward step past lower limit clamps there, holds while pin low
// - direction change continues from current frequency with new direction values
// - sync clock is sample clock divided by four
`include "dpsc_map.svh"
`default_nettype none
module dpsc_core
  import dpsc_pkg::*;
#(
  parameter int PHASE_W = `DPSC_PHASE_W,
  parameter int AMP_W   = `DPSC_AMP_W,
  parameter int RATE_W  = `DPSC_RATE_W,
  parameter int DEPTH   = `DPSC_FIFO_DEPTH
)
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset_n,
  input  wire logic [`DPSC_CF1_W-1:0] i_control_function_one,
  input  wire logic                 i_prof_we,
  input  wire logic [2:0]           i_prof_addr,
  input  wire dpsc_pkg::dpsc_word_t i_prof_freq_tuning_word,
  input  wire dpsc_pkg::dpsc_poff_t i_prof_phase_offset,
  input  wire dpsc_pkg::dpsc_word_t i_rising_step_word,
  input  wire dpsc_pkg::dpsc_word_t i_falling_step_word,
  input  wire logic [RATE_W-1:0]    i_rising_interval_word,
  input  wire logic [RATE_W-1:0]    i_falling_interval_word,
  input  wire logic                 i_profile_sel_bit0,
  input  wire logic                 i_profile_sel_bit1,
  input  wire logic                 i_profile_sel_bit2,
  input  wire logic                 i_dac_ready,
  output logic                      o_dac_valid,
  output logic [AMP_W-1:0]          o_dac_data,
  output logic                      o_sample_dropped,
  output dpsc_pkg::dpsc_mode_t      o_mode,
  output dpsc_pkg::dpsc_word_t      o_active_freq_tuning_word
);
  import dpsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // profile select pins, two-flop synchroniser
  logic [2:0] sel_meta_q;
  logic [2:0] sel_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sel_meta_q <= 3'h0;
      sel_q      <= 3'h0;
    end
    else
    begin
      sel_meta_q <= {i_profile_sel_bit2, i_profile_sel_bit1, i_profile_sel_bit0};
      sel_q      <= sel_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // profile storage
  dpsc_word_t prof_ftw_q [`DPSC_NUM_PROF];
  dpsc_poff_t prof_poff_q [`DPSC_NUM_PROF];
  genvar gp;
  generate
    for (gp = 0; gp < `DPSC_NUM_PROF; gp++)
    begin : g_prof
      always_ff @(posedge i_ref_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          prof_ftw_q[gp]  <= 48'h0;
          prof_poff_q[gp] <= 14'h0;
        end
        else if (i_prof_we && (i_prof_addr == 3'(gp)))
        begin
          prof_ftw_q[gp]  <= i_prof_freq_tuning_word;
          prof_poff_q[gp] <= i_prof_phase_offset;
        end
      end
    end
  endgenerate

  // one index picks both words of a profile
  wire        [2:0] act_idx  = sel_q;
  wire dpsc_word_t  act_ftw  = prof_ftw_q[act_idx];
  wire dpsc_poff_t  act_poff = prof_poff_q[act_idx];
  wire dpsc_word_t  lower    = prof_ftw_q[0];
  wire dpsc_word_t  upper    = prof_ftw_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire sweep_on = i_control_function_one[`DPSC_CF1_SWEEP_EN]
                  && !i_control_function_one[`DPSC_CF1_NODWELL];
  wire dir_up   = sel_q[0];
  assign o_mode = sweep_on ? DPSC_SWEEP : DPSC_TONE;

  ////////////////////////////////////////////////////////////////////////////
  // sync clock tick, sample clock divided by four
  logic [1:0] div_q;
  wire        sync_tick = (div_q == 2'(`DPSC_SYNC_DIV - 1));
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sweep interval counter and frequency accumulator
  logic [RATE_W-1:0] ivl_cnt_q;
  logic              dir_q;
  logic              sweep_q;
  dpsc_word_t        sweep_ftw_q;
  wire [RATE_W-1:0]  ivl_word = dir_up ? i_rising_interval_word
                                       : i_falling_interval_word;
  wire               dir_chg  = (dir_up != dir_q) || !sweep_q;
  wire               ivl_done = sync_tick && (ivl_cnt_q + 1'b1 >= ivl_word);
  wire        [48:0] up_sum   = {1'b0, sweep_ftw_q} + {1'b0, i_rising_step_word};
  wire        [48:0] dn_diff  = {1'b0, sweep_ftw_q} - {1'b0, i_falling_step_word};
  wire dpsc_word_t   up_next  = (up_sum[48] || (up_sum[47:0] > upper))
                                ? upper : up_sum[47:0];
  wire dpsc_word_t   dn_next  = (dn_diff[48] || (dn_diff[47:0] < lower))
                                ? lower : dn_diff[47:0];
  wire               step     = sweep_on && !dir_chg && ivl_done;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ivl_cnt_q   <= '0;
      dir_q       <= 1'b0;
      sweep_q     <= 1'b0;
      sweep_ftw_q <= 48'h0;
    end
    else
    begin
      sweep_q <= sweep_on;
      dir_q   <= dir_up;
      if (!sweep_on)
        sweep_ftw_q <= lower;
      else if (step)
        sweep_ftw_q <= dir_up ? up_next : dn_next;
      if (dir_chg || step)
        ivl_cnt_q <= '0;
      else if (sync_tick)
        ivl_cnt_q <= ivl_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase accumulator and offset
  dpsc_word_t       acc_q;
  wire dpsc_word_t  ftw_now = sweep_on ? sweep_ftw_q : act_ftw;
  assign o_active_freq_tuning_word = ftw_now;
  logic [AMP_W-1:0] phase_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      acc_q   <= 48'h0;
      phase_q <= '0;
    end
    else
    begin
      acc_q   <= acc_q + ftw_now;
      phase_q <= acc_q[47 -: 14] + act_poff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cosine stage: quarter-wave table with quadrant folding
  function automatic logic [12:0] dpsc_qcos(input logic [5:0] a);
    real x;
    x = $cos((real'(a) + 0.5) * 3.14159265358979 / 128.0);
    return 13'($rtoi(x * 8191.0));
  endfunction

  logic [12:0] lut [64];
  genvar gl;
  generate
    for (gl = 0; gl < 64; gl++)
    begin : g_lut
      assign lut[gl] = dpsc_qcos(6'(gl));
    end
  endgenerate

  wire   [1:0] quad   = phase_q[13:12];
  wire   [5:0] fine   = phase_q[11:6];
  wire   [5:0] lidx   = quad[0] ? ~fine : fine;
  wire  [12:0] mag    = lut[lidx];
  wire         neg    = quad[0] ^ quad[1];
  wire  [13:0] amp    = neg ? (14'h2000 - {1'b0, mag}) : (14'h2000 + {1'b0, mag});

  logic [AMP_W-1:0] amp_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      amp_q <= '0;
    else
      amp_q <= amp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // dac fifo, one word per sample
  logic in_ready;
  logic amp_vld_q;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      amp_vld_q        <= 1'b0;
      o_sample_dropped <= 1'b0;
    end
    else
    begin
      amp_vld_q        <= 1'b1;
      o_sample_dropped <= amp_vld_q && !in_ready;
    end
  end

  dpsc_fifo #(.WIDTH(AMP_W), .DEPTH(DEPTH)) u_fifo
  (
    .i_ref_clk   (i_ref_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (amp_vld_q),
    .o_in_ready  (in_ready),
    .i_in_data   (amp_q),
    .o_out_valid (o_dac_valid),
    .i_out_ready (i_dac_ready),
    .o_out_data  (o_dac_data)
  );
endmodule
`default_nettype wire

// ### dpsc_core_chk.sv
// assertion checker on the ports of the dds profile sweep core
`default_nettype none
module dpsc_core_chk
  import dpsc_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic [31:0] i_control_function_one,
  input wire logic        i_prof_we,
  input wire logic [2:0]  i_prof_addr,
  input wire dpsc_word_t  i_prof_freq_tuning_word,
  input wire dpsc_word_t  i_rising_step_word,
  input wire dpsc_word_t  i_falling_step_word,
  input wire logic        i_profile_sel_bit0,
  input wire logic        i_profile_sel_bit1,
  input wire logic        i_profile_sel_bit2,
  input wire logic        i_dac_ready,
  input wire logic        o_dac_valid,
  input wire logic [13:0] o_dac_data,
  input wire logic        o_sample_dropped,
  input wire dpsc_mode_t  o_mode,
  input wire dpsc_word_t  o_active_freq_tuning_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic [2:0] sel = {i_profile_sel_bit2, i_profile_sel_bit1, i_profile_sel_bit0};
  wire logic       swp = i_control_function_one[17] & ~i_control_function_one[16];
  wire dpsc_word_t w   = o_active_freq_tuning_word;
  dpsc_word_t      prof_q [8];
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the profile tuning words
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) prof_q <= '{default: '0};
    else if (i_prof_we) prof_q[i_prof_addr] <= i_prof_freq_tuning_word;
  ////////////////////////////////////////////////////////////////////////////////
  a_mode_decode: assert property (o_mode == (swp ? DPSC_SWEEP : DPSC_TONE))
    else $error("mode decode wrong");
  a_tone_profile_word: assert property (!swp && $past(!swp) && sel == $past(sel) &&
    sel == $past(sel, 2) && sel == $past(sel, 3) |-> w == prof_q[sel])
    else $error("tone word not from selected profile");
  a_sweep_within_limits: assert property (swp && $past(swp) |->
    w >= prof_q[0] && w <= prof_q[1]) else $error("sweep word outside limits");
  a_sweep_step_size: assert property (swp && $past(swp) && $changed(w) |->
    w == prof_q[0] || w == prof_q[1] || w == $past(w) + $past(i_rising_step_word) ||
    w == $past(w) - $past(i_falling_step_word)) else $error("sweep step size wrong");
  a_step_min_spacing: assert property (swp && $past(swp) && $changed(w) |=>
    (!swp || $stable(w))[*3]) else $error("sweep steps too close");
  a_dac_word_holds: assert property (o_dac_valid && !i_dac_ready |=>
    o_dac_valid && $stable(o_dac_data)) else $error("dac word not held");
  a_dac_flow_on: assert property (o_dac_valid && i_dac_ready |=> o_dac_valid)
    else $error("dac stream gap");
  a_drop_only_full: assert property (o_sample_dropped |-> $past(!i_dac_ready, 2) && o_dac_valid)
    else $error("drop without back pressure");
  c_upper_clamp: cover property (swp && $changed(w) && w == prof_q[1]);
  c_drop: cover property (o_sample_dropped);
  c_tone_change: cover property (!swp && $changed(w));
endmodule
`default_nettype wire

// ### dpsc_dac_model.sv
// dac sink and profile pin driver facing the dds profile sweep core
`default_nettype none
module dpsc_dac_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_stall,
  input  wire logic [2:0] i_sel,
  input  wire logic       i_dac_valid,
  output logic            o_dac_ready,
  output logic      [2:0] o_pins,
  output int              o_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_dac_ready = 1'b1;
    o_pins = 3'h0;
    o_taken = 0;
  end
  // pins follow the requested profile, bit 0 doubles as sweep direction
  always @(posedge i_ref_clk)
  begin
    o_pins <= i_sel;
    o_dac_ready <= !i_stall;
    if (i_dac_valid && o_dac_ready) o_taken <= o_taken + 1;
  end
endmodule
`default_nettype wire

// ### dpsc_core_tb.sv
// self-checking bench for the dds profile sweep core
`default_nettype none
module dpsc_core_tb;
  import dpsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [2:0] s; dpsc_word_t f; dpsc_poff_t p; } dpsc_row_t;
  logic        i_ref_clk = 0, i_reset_n = 0, we = 0, stall = 0, dac_ready, vld, drop;
  logic [31:0] cf1 = 0;
  logic [2:0]  addr = 0, sel = 0, pins;
  logic [15:0] rint = 0, fint = 0;
  logic [13:0] data;
  dpsc_word_t  freq_tuning_word = 0, rstep = 0, fstep = 0, word, prev;
  dpsc_poff_t  poff = 0;
  dpsc_mode_t  mode;
  int          failures = 0, num_checks = 0, taken, n;
  real         e;
  dpsc_row_t   rows [8] = '{
    '{3'h5, 48'h2222, 14'h0800}, '{3'h0, 48'h0, 14'h0000}, '{3'h3, 48'h3333, 14'h1800},
    '{3'h6, 48'h6666, 14'h3000}, '{3'h1, 48'h1111, 14'h1000}, '{3'h7, 48'h7777, 14'h3800},
    '{3'h2, 48'h2, 14'h2000}, '{3'h4, 48'h4444, 14'h2800}};
  always #20 i_ref_clk = ~i_ref_clk;
  dpsc_core dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_control_function_one(cf1),
    .i_prof_we(we), .i_prof_addr(addr), .i_prof_freq_tuning_word(freq_tuning_word), .i_prof_phase_offset(poff),
    .i_rising_step_word(rstep), .i_falling_step_word(fstep), .i_rising_interval_word(rint),
    .i_falling_interval_word(fint), .i_profile_sel_bit0(pins[0]), .i_profile_sel_bit1(pins[1]),
    .i_profile_sel_bit2(pins[2]), .i_dac_ready(dac_ready), .o_dac_valid(vld), .o_dac_data(data),
    .o_sample_dropped(drop), .o_mode(mode), .o_active_freq_tuning_word(word));
  dpsc_dac_model partner (.i_ref_clk(i_ref_clk), .i_stall(stall), .i_sel(sel),
    .i_dac_valid(vld), .o_dac_ready(dac_ready), .o_pins(pins), .o_taken(taken));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] expd);
    num_checks++;
    if (seen !== expd)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // waits for the next change of the active tuning word, counting cycles
  task automatic next_step(output int cyc);
    prev = word;
    cyc = 0;
    while (word === prev)
    begin
      @(negedge i_ref_clk);
      cyc++;
      if (cyc > 100)
      begin
        failures++;
        complete_run();
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1;
    foreach (rows[i])
    begin
      @(posedge i_ref_clk);
      {we, addr, freq_tuning_word, poff} <= {1'b1, rows[i].s, rows[i].f, rows[i].p};
    end
    @(posedge i_ref_clk) we <= 0;
    foreach (rows[i])
    begin
      @(posedge i_ref_clk) sel <= rows[i].s;
      repeat (8) @(negedge i_ref_clk);
      check(word, rows[i].f);
      e = 8192.0 + 8191.0 * $cos(6.2831853 * rows[i].p / 16384.0);
      check(data > e - 256.0 && data < e + 256.0, 1);
    end
    for (int m = 0; m < 4; m++)
    begin
      @(posedge i_ref_clk) cf1 <= 32'(m) << 16;
      @(negedge i_ref_clk) check(mode, (m == 2) ? DPSC_SWEEP : DPSC_TONE);
    end
    @(posedge i_ref_clk) {rstep, fstep, rint, fint} <= {48'h400, 48'h800, 16'h2, 16'h2};
    @(posedge i_ref_clk) {sel, cf1} <= {3'h1, 32'h0002_0000};
    repeat (2) @(negedge i_ref_clk);
    check(word, 0);
    for (int k = 1; k <= 5; k++)
    begin
      next_step(n);
      check(word, (k == 5) ? 48'h1111 : 48'h400 * k);
      if (k > 1) check(n, 8);
    end
    repeat (20) @(negedge i_ref_clk);
    check(word, 48'h1111);
    @(posedge i_ref_clk) sel <= 3'h0;
    next_step(n);
    check(word, 48'h911);
    @(posedge i_ref_clk) sel <= 3'h1;
    next_step(n);
    check(word, 48'hD11);
    @(posedge i_ref_clk) sel <= 3'h0;
    next_step(n);
    check(word, 48'h511);
    @(posedge i_ref_clk) fint <= 16'h1;
    next_step(n);
    check({word, n[7:0]}, {48'h0, 8'h4});
    repeat (20) @(negedge i_ref_clk);
    check(word, 0);
    @(posedge i_ref_clk) {cf1, stall} <= {32'h0, 1'b1};
    n = 0;
    repeat (40) @(negedge i_ref_clk) n += drop;
    check({n > 0, vld}, 2'b11);
    @(posedge i_ref_clk) stall <= 0;
    repeat (3) @(negedge i_ref_clk);
    n = taken;
    repeat (20) @(negedge i_ref_clk);
    check(taken - n, 20);
    @(posedge i_ref_clk) i_reset_n <= 0;
    @(negedge i_ref_clk) check(vld, 0);
    @(posedge i_ref_clk) i_reset_n <= 1;
    complete_run();
  end
endmodule
bind dpsc_core dpsc_core_chk chk (.*);
`default_nettype wire
